/* rtl/tam_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tam_consts.svh"
module tam_monitor import tam_pkg::*; #(
   parameter int LBL_CYCLES = `LBL_CYCLES
) (
   input wire logic MCLK, // system clock
   input wire logic NRST, // sync reset, low
   input wire logic [7:0] REG_ADDR, // register address
   input wire logic REG_RD, // read strobe, high for the cycle
   output logic [7:0] REG_RDATA, // read data
   input wire logic V5_STB, // V5 byte valid
   input wire logic [7:0] V5_BYTE, // received V5, bit7 = V5 bit 1
   input wire logic [1:0] PARITY_ERRS, // BIP-2 errors of frame, with V5_STB
   input wire logic Z7_STB, // Z7 byte valid
   input wire logic [7:0] Z7_BYTE, // received Z7
   input wire logic J2_STB, // J2 byte valid
   input wire logic [7:0] J2_BYTE, // received J2
   input wire logic Z6_STB, // Z6 byte valid
   input wire logic [7:0] Z6_BYTE, // received Z6
   input wire logic OBITS_STB, // both nibbles valid
   input wire logic [7:0] OBITS_BYTE, // overhead nibbles, one frame
   input wire logic POS_JUST, // positive justification pulse
   input wire logic NEG_JUST, // negative justification pulse
   input wire logic B_POINTER_LOST, // pointer lost
   input wire logic B_TRIBUTARY_ALARM_SIGNAL, // tributary AIS
   input wire logic B_MULTIFRAME_INDICATOR_ALARM, // H4 alarm
   input wire logic B_UPSTREAM_ALARM_SIGNAL, // upstream AIS
   input wire logic DEFECT_PERSISTENCE_SELECT, // 1: ten events
   input wire logic POINTER_REFERENCE_SELECT, // H4 alarm ignored when 1
   input wire logic HEADER_ALARM_QUALIFY_ENABLE, // upstream AIS counts when 1
   input wire logic BLOCK_COUNT, // one count per errored frame
   input wire logic [2:0] EXPECTED_LABEL, // software-written label
   input wire logic RESET_COUNTERS, // clears violation counter
   input wire logic FRAME_SYNC, // frame pulse
   input wire logic RX_FIFO_SLIP, // receive FIFO over/underflow
   input wire logic ADD_A_FIFO_SLIP, // add A FIFO over/underflow
   input wire logic ADD_B_FIFO_SLIP, // add B FIFO over/underflow
   output logic RX_FIFO_RESET, // receive FIFO reset pulse
   output logic ADD_A_FIFO_HOLD, // add A FIFO held in reset
   output logic ADD_B_FIFO_HOLD, // add B FIFO held in reset
   input wire logic NRZ_MODE, // T1 side is NRZ
   input wire logic B8ZS_MODE, // B8ZS line code
   input wire logic T1_TRANSMIT_CLOCK_IN, // T1 clock pin
   input wire logic T1_POSITIVE_RAIL_IN, // positive rail / NRZ data
   input wire logic T1_NEGATIVE_RAIL_IN // negative rail / LOS pin
);
   tam_state_s s_r, s_nxt;

   // next-state logic for the whole block
   always_comb begin
      logic rd_end, t1_rise, mark, suppress, cv_inc, cv_busy;
      logic [2:0] lbl, z7b;
      logic [2:0] hit;
      logic [3:0] need;
      logic [7:0] b_live, t_live, p_live;
      logic [8:0] bip_sum;
      rd_end = 1'b0;
      t1_rise = 1'b0;
      mark = 1'b0;
      suppress = 1'b0;
      cv_inc = 1'b0;
      cv_busy = 1'b0;
      lbl = 3'h0;
      z7b = 3'h0;
      hit = 3'h0;
      need = 4'h0;
      b_live = 8'h00;
      t_live = 8'h00;
      p_live = 8'h00;
      bip_sum = 9'h000;
      s_nxt = s_r;
      // two-flop pin synchronisers, edges taken from second stage only
      s_nxt.tci_m = T1_TRANSMIT_CLOCK_IN;
      s_nxt.tci_q = s_r.tci_m;
      s_nxt.tci_d = s_r.tci_q;
      s_nxt.tpi_m = T1_POSITIVE_RAIL_IN;
      s_nxt.tpi_q = s_r.tpi_m;
      s_nxt.tni_m = T1_NEGATIVE_RAIL_IN;
      s_nxt.tni_q = s_r.tni_m;
      t1_rise = s_r.tci_q & ~s_r.tci_d;
      mark = s_r.tpi_q | s_r.tni_q;

      // read cycle tracking; clear-on-read acts when the strobe drops
      s_nxt.rd_d = REG_RD;
      if (REG_RD && !s_r.rd_d) begin
         s_nxt.rd_addr = REG_ADDR;
      end
      rd_end = s_r.rd_d & ~REG_RD;
      cv_busy = REG_RD && (REG_ADDR == `OFS_CV_LO || REG_ADDR == `OFS_CV_HI);

      // V5 label bits 5..7 sit in V5_BYTE[3:1]; field bit 2 is V5 bit 7
      lbl = {V5_BYTE[1], V5_BYTE[2], V5_BYTE[3]};
      // Z7 arrives in its own slot before V5, so judge the stored copy, not the live bus
      z7b = {s_r.z7[3], s_r.z7[2], s_r.z7[1]};
      suppress = B_POINTER_LOST | B_TRIBUTARY_ALARM_SIGNAL
         | (B_MULTIFRAME_INDICATOR_ALARM & ~POINTER_REFERENCE_SELECT)
         | (B_UPSTREAM_ALARM_SIGNAL & HEADER_ALARM_QUALIFY_ENABLE);
      need = DEFECT_PERSISTENCE_SELECT ? `PERSIST_LONG : `PERSIST_SHORT;

      // defect detectors judged once per V5 frame
      hit[2] = (z7b == `Z7_RDIS) || (V5_BYTE[0] && (z7b[1:0] == 2'b00
         || z7b[1:0] == 2'b11));
      hit[1] = (z7b == `Z7_RDIP);
      hit[0] = (z7b == `Z7_RDIC);
      if (V5_STB) begin
         for (int i = 0; i < 3; i++) begin
            // independent set and clear runs so one stray frame resets a run
            if (hit[i]) begin
               s_nxt.def_clr[i] = 4'h0;
               if (s_r.def_set[i] < need) s_nxt.def_set[i] = s_r.def_set[i] + 4'h1;
               if (s_r.def_set[i] + 4'h1 >= need) s_nxt.def[i] = 1'b1;
            end else begin
               s_nxt.def_set[i] = 4'h0;
               if (s_r.def_clr[i] < need) s_nxt.def_clr[i] = s_r.def_clr[i] + 4'h1;
               if (s_r.def_clr[i] + 4'h1 >= need) s_nxt.def[i] = 1'b0;
            end
         end
         s_nxt.rfi = V5_BYTE[4];
         s_nxt.lbl_live = lbl;
         // unequipped: a run of five either way flips the alarm
         if (suppress) begin
            s_nxt.uneq = 1'b0;
            s_nxt.uneq_cnt = 3'h0;
         end else if ((lbl == `LBL_UNEQ) != s_r.uneq) begin
            s_nxt.uneq_cnt = s_r.uneq_cnt + 3'h1;
            if (s_r.uneq_cnt + 3'h1 >= `LABEL_RUN) begin
               s_nxt.uneq = ~s_r.uneq;
               s_nxt.uneq_cnt = 3'h0;
            end
         end else begin
            s_nxt.uneq_cnt = 3'h0;
         end
         // mismatch; 000 and 111 are left to other alarms
         if (suppress || lbl == `LBL_UNEQ || lbl == `LBL_AIS) begin
            s_nxt.mism_cnt = 3'h0;
            if (suppress) s_nxt.mism = 1'b0;
         end else if (((lbl != EXPECTED_LABEL) && (lbl != `LBL_ONE)) != s_r.mism) begin
            s_nxt.mism_cnt = s_r.mism_cnt + 3'h1;
            if (s_r.mism_cnt + 3'h1 >= `LABEL_RUN) begin
               s_nxt.mism = ~s_r.mism;
               s_nxt.mism_cnt = 3'h0;
            end
         end else begin
            s_nxt.mism_cnt = 3'h0;
         end
      end

      // received label register refreshed on a fixed tick
      if (s_r.lbl_tmr >= 15'(LBL_CYCLES - 1)) begin
         s_nxt.lbl_tmr = 15'h0000;
         s_nxt.lbl_reg = s_r.lbl_live;
      end else begin
         s_nxt.lbl_tmr = s_r.lbl_tmr + 15'h0001;
      end

      // overhead byte capture, first bit of each byte already in bit 7
      if (J2_STB) s_nxt.j2 = J2_BYTE;
      if (Z6_STB) s_nxt.z6 = Z6_BYTE;
      if (Z7_STB) s_nxt.z7 = Z7_BYTE;
      if (OBITS_STB) s_nxt.obits = OBITS_BYTE;

      // performance counters; clear on read end, saturating otherwise
      if (POS_JUST && s_r.pj != 4'hF) s_nxt.pj = s_r.pj + 4'h1;
      if (NEG_JUST && s_r.nj != 4'hF) s_nxt.nj = s_r.nj + 4'h1;
      bip_sum = BLOCK_COUNT ? {8'h00, |PARITY_ERRS}
         : {7'h00, PARITY_ERRS};
      bip_sum = bip_sum + {1'b0, s_r.bip};
      if (V5_STB) begin
         s_nxt.bip = bip_sum[8] ? 8'hFF : bip_sum[7:0];
         if (V5_BYTE[5] && s_r.febe != 8'hFF) s_nxt.febe = s_r.febe + 8'h01;
      end
      // a count arriving with the read clear survives it: set wins
      if (rd_end && s_r.rd_addr == `OFS_PJ) begin
         s_nxt.pj = {3'h0, POS_JUST};
         s_nxt.nj = {3'h0, NEG_JUST};
      end
      if (rd_end && s_r.rd_addr == `OFS_BIP) begin
         s_nxt.bip = V5_STB ? bip_sum[7:0] - s_r.bip : 8'h00;
      end
      if (rd_end && s_r.rd_addr == `OFS_FEBE) begin
         s_nxt.febe = {7'h00, V5_STB & V5_BYTE[5]};
      end

      // FIFO error handling; receive FIFO just pulses a reset
      s_nxt.rx_ffe = RX_FIFO_SLIP;
      if (ADD_A_FIFO_SLIP) begin
         s_nxt.a_hold = 2'h2;
      end else if (FRAME_SYNC && s_r.a_hold != 2'h0) begin
         s_nxt.a_hold = s_r.a_hold - 2'h1;
      end
      if (ADD_B_FIFO_SLIP) begin
         s_nxt.b_hold = 2'h2;
      end else if (FRAME_SYNC && s_r.b_hold != 2'h0) begin
         s_nxt.b_hold = s_r.b_hold - 2'h1;
      end

      // loss of clock measured in system clocks between synced edges
      if (s_r.tci_q != s_r.tci_d) begin
         s_nxt.loc_cnt = 9'h000;
         s_nxt.loc = 1'b0;
      end else if (s_r.loc_cnt < `LOC_CYC) begin
         s_nxt.loc_cnt = s_r.loc_cnt + 9'h001;
      end else begin
         s_nxt.loc = 1'b1;
      end

      // line monitors work per pulse position on the clock rising edge, except NRZ loss of signal, which follows the pin every system clock
      if (NRZ_MODE) begin
         s_nxt.los = ~s_r.tni_q;
      end
      if (t1_rise) begin
         if (!NRZ_MODE) begin
            s_nxt.los_zero = mark ? 8'h00 : s_r.los_zero + {7'h00, s_r.los_zero != 8'hFF};
            if (!mark && s_r.los_zero + 8'h01 >= `LOS_SPAN) s_nxt.los = 1'b1;
            // density window: clear only if enough marks in one full span
            s_nxt.los_ones = s_r.los_ones + {7'h00, mark};
            s_nxt.los_win = s_r.los_win + 8'h01;
            if (s_r.los_win + 8'h01 >= `LOS_SPAN) begin
               if (s_r.los_ones + {7'h00, mark} >= `LOS_MIN_ONES && s_nxt.los_zero == 8'h00)
                  s_nxt.los = 1'b0;
               s_nxt.los_win = 8'h00;
               s_nxt.los_ones = 8'h00;
            end
            // bipolar violation unless it looks like a B8ZS substitution
            if (mark) begin
               cv_inc = (s_r.tpi_q == s_r.last_pos) && !(s_r.tpi_q && s_r.tni_q)
                  && !(B8ZS_MODE && s_r.zero_run == 2'h3);
               s_nxt.last_pos = s_r.tpi_q;
               s_nxt.zero_run = 2'h0;
            end else if (s_r.zero_run != 2'h3) begin
               s_nxt.zero_run = s_r.zero_run + 2'h1;
            end
         end
         // all-ones run; only reported, nothing else reacts
         if (NRZ_MODE ? s_r.tpi_q : mark) begin
            if (s_r.ais_cnt != `AIS_RUN) s_nxt.ais_cnt = s_r.ais_cnt + 12'h001;
            else s_nxt.ais = 1'b1;
         end else begin
            s_nxt.ais_cnt = 12'h000;
            s_nxt.ais = 1'b0;
         end
      end

      // violation counter; counts seen mid-read wait in a pending bit
      if (cv_busy) begin
         s_nxt.cv_pend = s_r.cv_pend | cv_inc;
      end else begin
         s_nxt.cv_pend = 1'b0;
         if ((cv_inc || s_r.cv_pend) && s_r.cv != `CV_MAX) s_nxt.cv = s_r.cv + 16'h0001;
      end
      if (rd_end && s_r.rd_addr == `OFS_CV_LO) begin
         // low byte read first snaps the high byte, so the pair stays coherent
         s_nxt.cv_hi_snap = s_r.cv[15:8];
         s_nxt.cv = {15'h0000, s_r.cv_pend};
      end
      if (RESET_COUNTERS) begin
         s_nxt.cv = 16'h0000;
         s_nxt.cv_hi_snap = 8'h00;
         s_nxt.cv_pend = 1'b0;
      end

      // live bytes and their latched twins; a new alarm beats a read clear
      b_live = {B_TRIBUTARY_ALARM_SIGNAL, B_POINTER_LOST, 2'b00,
         s_r.def[2], s_r.rfi, s_r.uneq, s_r.mism};
      t_live = {s_r.rx_ffe, 2'b00, s_r.a_hold != 2'h0, s_r.b_hold != 2'h0,
         s_r.los, s_r.loc, s_r.ais};
      p_live = {s_r.def[1], s_r.def[0], 6'h00};
      s_nxt.lat_b = ((rd_end && s_r.rd_addr == `OFS_B_ALARMS_LAT) ? 8'h00 : s_r.lat_b)
         | b_live;
      s_nxt.lat_t = ((rd_end && s_r.rd_addr == `OFS_TX_LAT) ? 8'h00 : s_r.lat_t)
         | t_live;
      s_nxt.lat_p = ((rd_end && s_r.rd_addr == `OFS_PC_LAT) ? 8'h00 : s_r.lat_p)
         | p_live;

      // read mux, registered so data lands one clock after the address
      unique case (REG_ADDR)
         `OFS_B_ALARMS: s_nxt.rdata = b_live;
         `OFS_B_ALARMS_LAT: s_nxt.rdata = s_r.lat_b;
         `OFS_PJ: s_nxt.rdata = {s_r.pj, s_r.nj};
         `OFS_BIP: s_nxt.rdata = s_r.bip;
         `OFS_FEBE: s_nxt.rdata = s_r.febe;
         `OFS_LABEL: s_nxt.rdata = {5'h00, s_r.lbl_reg};
         `OFS_J2: s_nxt.rdata = s_r.j2;
         `OFS_Z6: s_nxt.rdata = s_r.z6;
         `OFS_Z7: s_nxt.rdata = s_r.z7;
         `OFS_OBITS: s_nxt.rdata = s_r.obits;
         `OFS_TX_LAT: s_nxt.rdata = s_r.lat_t;
         `OFS_TX: s_nxt.rdata = t_live;
         `OFS_CV_LO: s_nxt.rdata = s_r.cv[7:0];
         `OFS_CV_HI: s_nxt.rdata = s_r.cv_hi_snap;
         `OFS_PC_LAT: s_nxt.rdata = s_r.lat_p;
         `OFS_PC: s_nxt.rdata = p_live;
         default: s_nxt.rdata = 8'h00;
      endcase
   end

   // single state register
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign REG_RDATA = s_r.rdata;
   assign RX_FIFO_RESET = s_r.rx_ffe;
   assign ADD_A_FIFO_HOLD = s_r.a_hold != 2'h0;
   assign ADD_B_FIFO_HOLD = s_r.b_hold != 2'h0;

   logic rd_end_w, cv_busy_w;
   assign rd_end_w = s_r.rd_d & ~REG_RD;
   assign cv_busy_w = REG_RD && (REG_ADDR == `OFS_CV_LO || REG_ADDR == `OFS_CV_HI);

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);

   chk_rfi_follows: assert property (V5_STB |=> s_r.rfi == $past(V5_BYTE[4]))
      else $error("remote failure flag not following V5");
   chk_pj_saturates: assert property (s_r.pj == 4'hF && !(rd_end_w && s_r.rd_addr == `OFS_PJ)
      |=> s_r.pj == 4'hF)
      else $error("justification counter wrapped");
   chk_bip_block: assert property (V5_STB && BLOCK_COUNT && s_r.bip < 8'hF0
      && !(rd_end_w && s_r.rd_addr == `OFS_BIP) |=> s_r.bip - $past(s_r.bip)
      == {7'h00, $past(|PARITY_ERRS)})
      else $error("block mode parity count wrong");
   chk_febe_count: assert property (V5_STB && V5_BYTE[5] && s_r.febe < 8'hF0
      && !(rd_end_w && s_r.rd_addr == `OFS_FEBE) |=> s_r.febe == $past(s_r.febe) + 8'h01)
      else $error("far-end counter missed");
   chk_uneq_suppr: assert property (V5_STB && B_POINTER_LOST |=> !s_r.uneq)
      else $error("unequipped raised during pointer loss");
   chk_mism_suppr: assert property (V5_STB && B_TRIBUTARY_ALARM_SIGNAL |=> !s_r.mism)
      else $error("mismatch raised during AIS");
   chk_add_hold: assert property (ADD_A_FIFO_SLIP |=> ADD_A_FIFO_HOLD [*2])
      else $error("add FIFO hold too short");
   chk_loc_clear: assert property (s_r.tci_q != s_r.tci_d |=> !s_r.loc)
      else $error("loss of clock not cleared by edge");
   chk_cv_hold: assert property (cv_busy_w && !RESET_COUNTERS |=> s_r.cv == $past(s_r.cv))
      else $error("violation counter moved during read");
   chk_latch_keep: assert property (s_r.los |=> s_r.lat_t[2])
      else $error("latched loss of signal dropped");
endmodule
`default_nettype wire

/* rtl/tam_consts.svh */
// What this block does
// - flag remote server defect on Z7 101 or V5 bit8 with Z7 bits6-7 00/11
// - remote failure follows V5 bit 4 at once, no filtering
// - unequipped sets after five labels 000, clears after five not 000
// - unequipped suppressed by pointer loss, AIS, qualified H4 or upstream AIS
// - mismatch sets after five bad labels, clears after five good or 001
// - no mismatch for labels 000/111 or during the suppressing alarms
// - two saturating 4-bit justification counters in one byte, clear on read
// - 8-bit saturating parity error counter, block mode counts one per frame
// - 8-bit saturating far-end error counter bumps on V5 bit 3
// - received label field refreshed every 500 us; 001 always accepted
// - each live alarm byte has a latched twin, same bit positions
// - payload defect on Z7 010, connectivity defect on 110, persistence filtered
// - capture J2, Z6, Z7 with register bit 7 the first bit
// - store both overhead nibbles of one frame together
// - receive FIFO error sets alarm and resets that FIFO only
// - add FIFO error sets alarm and holds FIFO reset up to two frames
// - loss of signal after 175 markless positions; recover at 12.5% density
// - NRZ mode takes loss of signal from low negative-rail pin
// - loss of clock after 10 stuck periods, recovers on first edge
// - all-ones line alarm is reported only
// - 16-bit saturating violation counter, cleared by reset, control or read
// - counts arriving during a violation counter read are applied afterwards
`ifndef TAM_CONSTS_SVH
`define TAM_CONSTS_SVH
`define OFS_B_ALARMS 8'h3B
`define OFS_B_ALARMS_LAT 8'h3A
`define OFS_PJ 8'h3C
`define OFS_BIP 8'h3D
`define OFS_FEBE 8'h3E
`define OFS_LABEL 8'h3F
`define OFS_J2 8'h40
`define OFS_Z6 8'h41
`define OFS_Z7 8'h42
`define OFS_OBITS 8'h43
`define OFS_TX_LAT 8'h44
`define OFS_TX 8'h45
`define OFS_CV_LO 8'h46
`define OFS_CV_HI 8'h47
`define OFS_PC_LAT 8'h5E
`define OFS_PC 8'h5F
`define PERSIST_SHORT 4'h5
`define PERSIST_LONG 4'hA
`define LABEL_RUN 3'h5
`define LBL_UNEQ 3'h0
`define LBL_ONE 3'h1
`define LBL_AIS 3'h7
`define Z7_RDIS 3'h5
`define Z7_RDIP 3'h2
`define Z7_RDIC 3'h6
`define MCLK_NS 20
`define LBL_PERIOD_US 500
`define LBL_CYCLES ((`LBL_PERIOD_US * 1000) / `MCLK_NS)
`define T1_PERIOD_NS 648
`define LOC_T1_CYCLES 10
`define LOC_CYC 9'((`LOC_T1_CYCLES * `T1_PERIOD_NS + `MCLK_NS - 1) / `MCLK_NS)
`define LOS_SPAN 8'hAF
`define LOS_MIN_ONES 8'h16
`define AIS_RUN 12'h800
`define CV_MAX 16'hFFFF
`endif

/* rtl/tam_pkg.sv */
package tam_pkg;
   typedef struct packed {
      logic tci_m, tci_q, tci_d, tpi_m, tpi_q, tni_m, tni_q;
      logic rd_d;
      logic [7:0] rd_addr;
      logic [7:0] rdata;
      logic [2:0] def;
      logic [2:0][3:0] def_set;
      logic [2:0][3:0] def_clr;
      logic rfi, uneq, mism;
      logic [2:0] uneq_cnt, mism_cnt;
      logic [2:0] lbl_live, lbl_reg;
      logic [14:0] lbl_tmr;
      logic [3:0] pj, nj;
      logic [7:0] bip, febe, j2, z6, z7, obits;
      logic rx_ffe;
      logic [1:0] a_hold, b_hold;
      logic los;
      logic [7:0] los_zero, los_win, los_ones;
      logic loc;
      logic [8:0] loc_cnt;
      logic ais;
      logic [11:0] ais_cnt;
      logic last_pos;
      logic [1:0] zero_run;
      logic [15:0] cv;
      logic [7:0] cv_hi_snap;
      logic cv_pend;
      logic [7:0] lat_b, lat_t, lat_p;
   } tam_state_s;
endpackage

/* verif/tam_oh_term.sv */
`timescale 1ns/1ns
`default_nettype none
module tam_oh_term (
   input wire logic clk, // system clock
   input wire logic go, // one-cycle frame request
   input wire logic [7:0] v5, // V5 of the frame
   input wire logic [7:0] z7, // Z7 of the frame
   input wire logic [7:0] j2, // J2; Z6 and O-bits derive from it
   input wire logic [1:0] perr, // parity errors of the frame
   output logic fsync, // frame start
   output logic j2_stb, // J2 on bus
   output logic z6_stb, // Z6 on bus
   output logic ob_stb, // O-bits on bus
   output logic z7_stb, // Z7 on bus
   output logic v5_stb, // V5 on bus
   output logic done, // frame finished
   output logic [7:0] bus, // shared byte lines
   output logic [1:0] pe // parity error lines
);
   logic [2:0] step = 3'h0;
   logic [7:0] cnt = 8'h00;
   // frame walk: sync, J2, Z6, O-bits, Z7, V5, done
   always_ff @(posedge clk) begin
      cnt <= cnt + 8'h01;
      if (go) begin
         step <= 3'h1;
      end else if (step != 3'h0) begin
         step <= step + 3'h1;
      end
   end
   // lines carry a changing pattern outside their slot, so stale bytes never look valid
   always_comb begin
      fsync = (step == 3'h1);
      {j2_stb, z6_stb, ob_stb, z7_stb, v5_stb} = 5'h10 >> (step - 3'h2);
      done = (step == 3'h7);
      case (step)
         3'h2: bus = j2;
         3'h3: bus = j2 ^ 8'h3C;
         3'h4: bus = {j2[3:0], j2[7:4]};
         3'h5: bus = z7;
         3'h6: bus = v5;
         default: bus = cnt ^ 8'h5A;
      endcase
      pe = (step == 3'h6) ? perr : cnt[1:0];
   end
endmodule
`default_nettype wire

/* verif/tributary_alarm_counter_monitor_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tributary_alarm_counter_monitor_tb;
   localparam int LBL = 50; // short label refresh keeps the run brief
   logic MCLK, NRST, REG_RD, POS_JUST, NEG_JUST, RESET_COUNTERS, BLOCK_COUNT, go, tclk_run;
   logic B_POINTER_LOST, B_TRIBUTARY_ALARM_SIGNAL, B_MULTIFRAME_INDICATOR_ALARM;
   logic B_UPSTREAM_ALARM_SIGNAL, DEFECT_PERSISTENCE_SELECT, POINTER_REFERENCE_SELECT;
   logic HEADER_ALARM_QUALIFY_ENABLE, RX_FIFO_SLIP, ADD_A_FIFO_SLIP, ADD_B_FIFO_SLIP;
   logic NRZ_MODE, B8ZS_MODE, T1_TRANSMIT_CLOCK_IN, T1_POSITIVE_RAIL_IN, T1_NEGATIVE_RAIL_IN;
   logic RX_FIFO_RESET, ADD_A_FIFO_HOLD, ADD_B_FIFO_HOLD;
   logic fsync, j2_stb, z6_stb, ob_stb, z7_stb, v5_stb, done;
   logic [7:0] REG_ADDR, REG_RDATA, v5, z7, j2, bus, rv;
   logic [2:0] EXPECTED_LABEL;
   logic [1:0] perr, pe;
   int bad_count, comparisons;
   tam_oh_term i_term (.clk(MCLK), .go, .v5, .z7, .j2, .perr, .fsync, .j2_stb, .z6_stb,
      .ob_stb, .z7_stb, .v5_stb, .done, .bus, .pe);
   tam_monitor #(.LBL_CYCLES(LBL)) i_dut (.MCLK, .NRST, .REG_ADDR, .REG_RD, .REG_RDATA,
      .V5_STB(v5_stb), .V5_BYTE(bus), .PARITY_ERRS(pe), .Z7_STB(z7_stb), .Z7_BYTE(bus),
      .J2_STB(j2_stb), .J2_BYTE(bus), .Z6_STB(z6_stb), .Z6_BYTE(bus), .OBITS_STB(ob_stb),
      .OBITS_BYTE(bus), .POS_JUST, .NEG_JUST, .B_POINTER_LOST, .B_TRIBUTARY_ALARM_SIGNAL,
      .B_MULTIFRAME_INDICATOR_ALARM, .B_UPSTREAM_ALARM_SIGNAL, .DEFECT_PERSISTENCE_SELECT,
      .POINTER_REFERENCE_SELECT, .HEADER_ALARM_QUALIFY_ENABLE, .BLOCK_COUNT, .EXPECTED_LABEL,
      .RESET_COUNTERS, .FRAME_SYNC(fsync), .RX_FIFO_SLIP, .ADD_A_FIFO_SLIP, .ADD_B_FIFO_SLIP,
      .RX_FIFO_RESET, .ADD_A_FIFO_HOLD, .ADD_B_FIFO_HOLD, .NRZ_MODE, .B8ZS_MODE,
      .T1_TRANSMIT_CLOCK_IN, .T1_POSITIVE_RAIL_IN, .T1_NEGATIVE_RAIL_IN);
   // system clock, and a link clock that stands still when stopped
   always #10 MCLK = ~MCLK;
   always #80 if (tclk_run) T1_TRANSMIT_CLOCK_IN = ~T1_TRANSMIT_CLOCK_IN;
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask
   // read ends at the edge where the strobe falls, which is when read-clears act
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      REG_ADDR = a;
      REG_RD = 1'b1;
      tick(1);
      rv = REG_RDATA;
      REG_RD = 1'b0;
      tick(1);
      chk(rv & m, e);
   endtask
   // fields stay put until the partner reports the frame done
   task automatic frm(input int n, input logic [7:0] a, input logic [7:0] b);
      int k;
      for (int i = 0; i < n; i++) begin
         v5 = a;
         z7 = b;
         go = 1'b1;
         tick(1);
         go = 1'b0;
         for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
         if (k == 20) begin
            bad_count++;
            end_of_test();
         end
      end
   endtask
   // rails change on the falling link edge, n pulse positions per call
   task automatic t1(input int n, input logic p, input logic q);
      repeat (n) begin
         @(negedge T1_TRANSMIT_CLOCK_IN);
         T1_POSITIVE_RAIL_IN = p;
         T1_NEGATIVE_RAIL_IN = q;
      end
      tick(2);
   endtask
   initial begin
      #2000000;
      bad_count++;
      end_of_test();
   end
   initial begin
      {MCLK, NRST, REG_RD, POS_JUST, NEG_JUST, RESET_COUNTERS, BLOCK_COUNT, go} = '0;
      {B_POINTER_LOST, B_TRIBUTARY_ALARM_SIGNAL, B_MULTIFRAME_INDICATOR_ALARM} = '0;
      {B_UPSTREAM_ALARM_SIGNAL, DEFECT_PERSISTENCE_SELECT, POINTER_REFERENCE_SELECT} = '0;
      {HEADER_ALARM_QUALIFY_ENABLE, RX_FIFO_SLIP, ADD_A_FIFO_SLIP, ADD_B_FIFO_SLIP} = '0;
      {NRZ_MODE, B8ZS_MODE, T1_TRANSMIT_CLOCK_IN, T1_POSITIVE_RAIL_IN, T1_NEGATIVE_RAIL_IN} = '0;
      {REG_ADDR, v5, z7, j2, perr, bad_count, comparisons} = '0;
      {EXPECTED_LABEL, tclk_run} = 4'h5;
      tick(3);
      NRST = 1'b1;
      foreach (rv[i]) rd(8'h3B + 8'(i), 8'hFF, 8'h00);
      rd(8'h10, 8'hFF, 8'h00);
      $display("test reset ended");
      HEADER_ALARM_QUALIFY_ENABLE = 1'b1;
      for (int i = 0; i < 4; i++) begin
         {B_POINTER_LOST, B_TRIBUTARY_ALARM_SIGNAL, B_MULTIFRAME_INDICATOR_ALARM,
            B_UPSTREAM_ALARM_SIGNAL} = 4'h8 >> i;
         frm(5, 8'h00, 8'h00);
         rd(8'h3B, 8'h03, 8'h00);
      end
      B_UPSTREAM_ALARM_SIGNAL = 1'b0;
      frm(5, 8'h04, 8'h00);
      frm(4, 8'h00, 8'h00);
      rd(8'h3B, 8'h03, 8'h00);
      frm(1, 8'h00, 8'h00);
      rd(8'h3B, 8'h03, 8'h02);
      frm(4, 8'h04, 8'h00);
      rd(8'h3B, 8'h03, 8'h02);
      frm(1, 8'h04, 8'h00);
      rd(8'h3B, 8'h03, 8'h00);
      frm(5, 8'h0A, 8'h00);
      rd(8'h3B, 8'h03, 8'h01);
      frm(5, 8'h04, 8'h00);
      rd(8'h3B, 8'h03, 8'h00);
      frm(5, 8'h0E, 8'h00);
      rd(8'h3B, 8'h03, 8'h00);
      frm(1, 8'h14, 8'h00);
      rd(8'h3B, 8'h04, 8'h04);
      frm(1, 8'h04, 8'h00);
      rd(8'h3B, 8'h04, 8'h00);
      $display("test labels ended");
      frm(4, 8'h04, 8'h0A);
      rd(8'h3B, 8'h08, 8'h00);
      frm(1, 8'h04, 8'h0A);
      rd(8'h3B, 8'h08, 8'h08);
      frm(5, 8'h04, 8'h00);
      rd(8'h3B, 8'h08, 8'h00);
      frm(5, 8'h05, 8'h00);
      rd(8'h3B, 8'h08, 8'h08);
      DEFECT_PERSISTENCE_SELECT = 1'b1;
      frm(5, 8'h04, 8'h00);
      rd(8'h3B, 8'h08, 8'h08);
      frm(5, 8'h04, 8'h00);
      rd(8'h3B, 8'h08, 8'h00);
      DEFECT_PERSISTENCE_SELECT = 1'b0;
      frm(5, 8'h04, 8'h04);
      rd(8'h5F, 8'hFF, 8'h80);
      frm(5, 8'h04, 8'h0C);
      rd(8'h5F, 8'hFF, 8'h40);
      rd(8'h5E, 8'hFF, 8'hC0);
      rd(8'h5E, 8'hFF, 8'h40);
      $display("test defects ended");
      perr = 2'h2;
      frm(130, 8'h04, 8'h00);
      rd(8'h3D, 8'hFF, 8'hFF);
      rd(8'h3D, 8'hFF, 8'h00);
      BLOCK_COUNT = 1'b1;
      frm(3, 8'h24, 8'h00);
      rd(8'h3D, 8'hFF, 8'h03);
      rd(8'h3E, 8'hFF, 8'h03);
      {perr, BLOCK_COUNT} = 3'h0;
      for (int i = 0; i < 19; i++) begin
         {POS_JUST, NEG_JUST} = (i < 17) ? 2'b10 : 2'b01;
         tick(1);
         {POS_JUST, NEG_JUST} = 2'b00;
         tick(1);
      end
      rd(8'h3C, 8'hFF, 8'hF2);
      rd(8'h3C, 8'hFF, 8'h00);
      j2 = 8'hA5;
      frm(1, 8'h04, 8'h81);
      rd(8'h40, 8'hFF, 8'hA5);
      rd(8'h41, 8'hFF, 8'h99);
      rd(8'h42, 8'hFF, 8'h81);
      rd(8'h43, 8'hFF, 8'h5A);
      tick(LBL + 10);
      rd(8'h3F, 8'hFF, 8'h02);
      $display("test counters ended");
      RX_FIFO_SLIP = 1'b1;
      tick(1);
      RX_FIFO_SLIP = 1'b0;
      chk({7'h00, RX_FIFO_RESET}, 8'h01);
      tick(1);
      chk({7'h00, RX_FIFO_RESET}, 8'h00);
      rd(8'h44, 8'h80, 8'h80);
      {ADD_A_FIFO_SLIP, ADD_B_FIFO_SLIP} = 2'b11;
      tick(1);
      {ADD_A_FIFO_SLIP, ADD_B_FIFO_SLIP} = 2'b00;
      chk({6'h00, ADD_A_FIFO_HOLD, ADD_B_FIFO_HOLD}, 8'h03);
      rd(8'h45, 8'h18, 8'h18);
      frm(2, 8'h04, 8'h00);
      tick(2);
      chk({6'h00, ADD_A_FIFO_HOLD, ADD_B_FIFO_HOLD}, 8'h00);
      $display("test fifo ended");
      t1(200, 1'b0, 1'b0);
      rd(8'h45, 8'h04, 8'h04);
      for (int i = 0; i < 200; i++) begin
         t1(1, 1'b1, 1'b0);
         t1(1, 1'b0, 1'b1);
      end
      t1(1, 1'b0, 1'b0);
      rd(8'h45, 8'h04, 8'h00);
      rd(8'h46, 8'h00, 8'h00);
      t1(4, 1'b1, 1'b0);
      t1(1, 1'b0, 1'b0);
      rd(8'h46, 8'hFF, 8'h03);
      rd(8'h47, 8'hFF, 8'h00);
      rd(8'h46, 8'hFF, 8'h00);
      t1(2, 1'b1, 1'b0);
      t1(1, 1'b0, 1'b0);
      RESET_COUNTERS = 1'b1;
      tick(1);
      RESET_COUNTERS = 1'b0;
      rd(8'h46, 8'hFF, 8'h00);
      B8ZS_MODE = 1'b1;
      t1(3, 1'b0, 1'b0);
      t1(1, 1'b1, 1'b0);
      t1(1, 1'b0, 1'b0);
      rd(8'h46, 8'hFF, 8'h00);
      NRZ_MODE = 1'b1;
      tick(10);
      rd(8'h45, 8'h04, 8'h04);
      t1(2100, 1'b1, 1'b1);
      rd(8'h45, 8'h05, 8'h01);
      tclk_run = 1'b0;
      tick(300);
      rd(8'h45, 8'h02, 8'h00);
      tick(100);
      rd(8'h45, 8'h02, 8'h02);
      tclk_run = 1'b1;
      tick(20);
      rd(8'h45, 8'h02, 8'h00);
      rd(8'h44, 8'h02, 8'h02);
      $display("test line ended");
      end_of_test();
   end
endmodule
`default_nettype wire
